// ---- shared/eq_search_pkg.sv ----
// Purpose: constants shared by the equalizer search control block
// Assumes: 8-bit registers reached through the device i2c port
// Notes:   field layouts beyond the floor-enable bit are local choices
package eq_search_pkg;
  localparam int CODE_W = 4;
  localparam logic [CODE_W-1:0] CODE_MIN = 4'h0;

  // register offsets
  localparam logic [7:0] ADDR_ERR_SRC    = 8'h42;
  localparam logic [7:0] ADDR_SEARCH_CTL = 8'hd2;
  localparam logic [7:0] ADDR_RESULT     = 8'hd3;
  localparam logic [7:0] ADDR_LIMITS     = 8'hd5;

  // eq_error_source_select fields
  localparam int SRC_CDR_BIT   = 0;
  localparam int SRC_ENC_BIT   = 1;
  localparam int SRC_PAR_BIT   = 2;
  localparam int SRC_CHECK_BIT = 3;
  localparam int THR_LSB       = 4;
  localparam int THR_W         = 4;

  // eq_search_control fields
  localparam int CTL_RESTART_BIT    = 0;
  localparam int CTL_FIRST_LOCK_BIT = 1;
  localparam int CTL_FLOOR_EN_BIT   = 2;
  localparam int DWELL_LSB          = 3;
  localparam int DWELL_W            = 3;

  // eq_search_limits fields
  localparam int LIM_FLOOR_LSB = 0;
  localparam int LIM_CEIL_LSB  = 4;

  // eq_result_status fields
  localparam int RES_CODE_LSB = 0;
  localparam int RES_HELD_BIT = 4;
  localparam int RES_LOCK_BIT = 5;

  // reset values
  localparam logic [7:0] ERR_SRC_RST = 8'h1f;
  localparam logic [7:0] CTL_RST     = 8'h02;
  localparam logic [7:0] LIMITS_RST  = 8'hf0;

  // dwell unit: 2.62 ms of a 25 MHz reference, kept as a cycle count
  localparam int DWELL_UNIT_NS = 2620000;
  localparam int REF_NOM_MHZ   = 25;
  localparam int DWELL_DEFAULT_CYCLES = DWELL_UNIT_NS * REF_NOM_MHZ / 1000;
  localparam int TIMER_W = 20;
  localparam int ERR_W   = 8;

  typedef enum logic [6:0] {
    I_IDLE     = 7'b0000001,
    I_ADDR     = 7'b0000010,
    I_ACK_ADDR = 7'b0000100,
    I_WRITE    = 7'b0001000,
    I_ACK_WR   = 7'b0010000,
    I_READ     = 7'b0100000,
    I_ACK_RD   = 7'b1000000
  } i2c_state_t;

  typedef enum logic [1:0] {
    S_SEARCH = 2'b01,
    S_HOLD   = 2'b10
  } search_state_t;
endpackage

// ---- hdl/eq_dwell_judge.sv ----
// Purpose: dwell timer and error accumulator for one gain code
// Assumes: err_pulse and clear are on ref_clk
// Notes:   expired pulses once per dwell interval
`timescale 1ns/1ns
module eq_dwell_judge #(
  parameter int DWELL_CYCLES = eq_search_pkg::DWELL_DEFAULT_CYCLES
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clear,
  input  wire logic [eq_search_pkg::DWELL_W-1:0] dwell_sel,
  input  wire logic                             err_pulse,
  input  wire logic [eq_search_pkg::THR_W-1:0]  err_thr,
  output logic                                  expired,
  output logic                                  err_over
);
  import eq_search_pkg::*;

  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] dwell_len;
  logic [TIMER_W-1:0] mult;
  logic [ERR_W-1:0]   err_cnt;
  logic               at_end;
  logic               in_window;

  // dwell scales in whole units of the reference cycle count
  always_comb begin
    mult = TIMER_W'(dwell_sel) + TIMER_W'(1);
    dwell_len = TIMER_W'(DWELL_CYCLES) * mult;
    // at or past the end, so a dwell shortened mid-interval still ends
    at_end = (timer >= dwell_len - TIMER_W'(1));
    in_window = (timer < (dwell_len >> 1));
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear || at_end) begin
      timer <= '0;
    end else begin
      timer <= timer + TIMER_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= at_end && !clear;
    end
  end

  // errors counted over the first half of each dwell, saturating
  always_ff @(posedge ref_clk) begin
    if (rst || clear || at_end) begin
      err_cnt <= '0;
    end else if (err_pulse && in_window && (err_cnt != '1)) begin
      err_cnt <= err_cnt + ERR_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      err_over <= 1'b0;
    end else begin
      err_over <= (err_cnt > ERR_W'(err_thr));
    end
  end
endmodule

// ---- hdl/adaptive_eq_search_control.sv ----
// Purpose: equalizer gain search control with i2c register access
// Assumes: ref_clk 25 MHz; scl/sda and cdr lock arrive asynchronously
// Notes:   link error strobes are single-cycle pulses on ref_clk
//
// Functional notes
// - writing the restart bit restarts the search at any time
// - after reset the search cycles through codes until one is judged good
// - with a compatible partner, first lock restarts the search once
// - restart bit or soft reset begins again from the lower bound (the floor when enabled)
// - the ceiling field bounds the highest code the search reaches
// - the floor value is where adaption starts
// - the floor applies only when the floor-enable bit is set
// - the chosen gain code is readable in the result register
// - each code is tried for one dwell interval before stepping
// - default dwell is the 2.62 ms count of a 25 MHz reference
// - past the ceiling without lock the search wraps to the bound
// - error checking takes part in judging codes by default
// - each error source is selectable in the source register
// - errors are counted over half the dwell interval
// - error count above threshold moves to the next code
// - on valid lock the code is held while lock persists and errors stay within threshold
// - on loss of lock the search advances to the next code
`timescale 1ns/1ns
module adaptive_eq_search_control #(
  parameter logic [6:0] DEV_ADDR     = 7'h30,
  parameter int         DWELL_CYCLES = eq_search_pkg::DWELL_DEFAULT_CYCLES
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  input  wire logic                            scl_in,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe_n,
  input  wire logic                            cdr_lock,
  input  wire logic                            cdr_error,
  input  wire logic                            enc_error,
  input  wire logic                            parity_error,
  input  wire logic                            compatible_partner,
  input  wire logic                            digital_soft_reset,
  output logic [eq_search_pkg::CODE_W-1:0]     eq_gain_code,
  output logic                                 eq_code_held
);
  import eq_search_pkg::*;

  // synchronisers
  logic scl_m, scl_s, scl_q;
  logic sda_m, sda_s, sda_q;
  logic lock_m, lock_s, lock_q;

  // i2c slave
  i2c_state_t     i_state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shreg;
  logic [7:0]     ptr;
  logic           rw;
  logic           first_byte;
  logic           nack;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic [7:0]     rd_data;
  logic           start_det;
  logic           stop_det;
  logic           scl_rise;
  logic           scl_fall;

  // registers
  logic [7:0]     err_src;
  logic [7:0]     search_ctl;
  logic [7:0]     limits;
  logic           restart_req;

  // search
  search_state_t  s_state;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] lower;
  logic [CODE_W-1:0] ceiling;
  logic [CODE_W-1:0] next_code;
  logic           clear;
  logic           first_lock_done;
  logic           first_lock_restart;
  logic           restart;
  logic           err_pulse;
  logic           expired;
  logic           err_over;
  logic           check_en;
  logic           code_good;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_m  <= 1'b1;
      scl_s  <= 1'b1;
      scl_q  <= 1'b1;
      sda_m  <= 1'b1;
      sda_s  <= 1'b1;
      sda_q  <= 1'b1;
      lock_m <= 1'b0;
      lock_s <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      scl_m  <= scl_in;
      scl_s  <= scl_m;
      scl_q  <= scl_s;
      sda_m  <= sda_in;
      sda_s  <= sda_m;
      sda_q  <= sda_s;
      lock_m <= cdr_lock;
      lock_s <= lock_m;
      lock_q <= lock_s;
    end
  end

  always_comb begin
    start_det = scl_s && scl_q && sda_q && !sda_s;
    stop_det  = scl_s && scl_q && !sda_q && sda_s;
    scl_rise  = scl_s && !scl_q;
    scl_fall  = !scl_s && scl_q;
  end

  // register read mux
  always_comb begin
    if (ptr == ADDR_ERR_SRC) begin
      rd_data = err_src;
    end else if (ptr == ADDR_SEARCH_CTL) begin
      rd_data = search_ctl;
    end else if (ptr == ADDR_RESULT) begin
      rd_data = '0;
      rd_data[RES_CODE_LSB +: CODE_W] = code;
      rd_data[RES_HELD_BIT] = (s_state == S_HOLD);
      rd_data[RES_LOCK_BIT] = lock_s;
    end else if (ptr == ADDR_LIMITS) begin
      rd_data = limits;
    end else begin
      rd_data = '0;
    end
  end

  // i2c slave: open-drain sda, only ever pulled low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      i_state    <= I_IDLE;
      bit_cnt    <= '0;
      shreg      <= '0;
      ptr        <= '0;
      rw         <= 1'b0;
      first_byte <= 1'b0;
      nack       <= 1'b0;
      sda_oe_n   <= 1'b1;
      wr_en      <= 1'b0;
      wr_addr    <= '0;
      wr_data    <= '0;
    end else begin
      wr_en <= 1'b0;
      if (start_det) begin
        i_state    <= I_ADDR;
        bit_cnt    <= '0;
        first_byte <= 1'b1;
        sda_oe_n   <= 1'b1;
      end else if (stop_det) begin
        i_state  <= I_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (i_state)
          I_ADDR, I_WRITE: begin
            if (scl_rise && bit_cnt != 4'd8) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
              if (i_state == I_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  sda_oe_n <= 1'b0;
                  rw       <= shreg[0];
                  i_state  <= I_ACK_ADDR;
                end else begin
                  i_state <= I_IDLE;
                end
              end else begin
                sda_oe_n <= 1'b0;
                i_state  <= I_ACK_WR;
                if (first_byte) begin
                  ptr        <= shreg;
                  first_byte <= 1'b0;
                end else begin
                  wr_en   <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= shreg;
                  ptr     <= ptr + 8'd1;
                end
              end
            end
          end
          I_ACK_ADDR: begin
            if (scl_fall) begin
              bit_cnt <= '0;
              if (rw) begin
                shreg    <= rd_data;
                sda_oe_n <= rd_data[7];
                i_state  <= I_READ;
              end else begin
                sda_oe_n <= 1'b1;
                i_state  <= I_WRITE;
              end
            end
          end
          I_ACK_WR: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= '0;
              i_state  <= I_WRITE;
            end
          end
          I_READ: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'd8) begin
                sda_oe_n <= 1'b1;
                ptr      <= ptr + 8'd1;
                i_state  <= I_ACK_RD;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_n <= shreg[6];
              end
            end
          end
          I_ACK_RD: begin
            if (scl_rise) begin
              nack <= sda_s;
            end else if (scl_fall) begin
              bit_cnt <= '0;
              if (nack) begin
                i_state <= I_IDLE;
              end else begin
                shreg    <= rd_data;
                sda_oe_n <= rd_data[7];
                i_state  <= I_READ;
              end
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // register writes; restart bit is a self-clearing command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_src     <= ERR_SRC_RST;
      search_ctl  <= CTL_RST;
      limits      <= LIMITS_RST;
      restart_req <= 1'b0;
    end else begin
      restart_req <= 1'b0;
      if (wr_en) begin
        if (wr_addr == ADDR_ERR_SRC) begin
          err_src <= wr_data;
        end else if (wr_addr == ADDR_SEARCH_CTL) begin
          search_ctl <= wr_data;
          search_ctl[CTL_RESTART_BIT] <= 1'b0;
          restart_req <= wr_data[CTL_RESTART_BIT];
        end else if (wr_addr == ADDR_LIMITS) begin
          limits <= wr_data;
        end
      end
    end
  end

  // selected link errors feed the accumulator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_pulse <= 1'b0;
    end else begin
      err_pulse <= (cdr_error && err_src[SRC_CDR_BIT])
                || (enc_error && err_src[SRC_ENC_BIT])
                || (parity_error && err_src[SRC_PAR_BIT]);
    end
  end

  // one restart on the first lock seen from a compatible partner
  always_comb begin
    first_lock_restart = lock_s && !lock_q && !first_lock_done
                      && compatible_partner
                      && search_ctl[CTL_FIRST_LOCK_BIT];
    restart = restart_req || digital_soft_reset
           || first_lock_restart;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_lock_done <= 1'b0;
    end else if (first_lock_restart) begin
      first_lock_done <= 1'b1;
    end
  end

  always_comb begin
    ceiling = limits[LIM_CEIL_LSB +: CODE_W];
    if (search_ctl[CTL_FLOOR_EN_BIT]) begin
      lower = limits[LIM_FLOOR_LSB +: CODE_W];
    end else begin
      lower = CODE_MIN;
    end
    if (code >= ceiling) begin
      next_code = lower;
    end else begin
      next_code = code + CODE_W'(1);
    end
    check_en  = err_src[SRC_CHECK_BIT];
    code_good = lock_s && !(check_en && err_over);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_state <= S_SEARCH;
      code    <= CODE_MIN;
      clear   <= 1'b1;
    end else begin
      clear <= 1'b0;
      if (restart) begin
        s_state <= S_SEARCH;
        code    <= lower;
        clear   <= 1'b1;
      end else begin
        case (s_state)
          S_SEARCH: begin
            if (expired) begin
              if (code_good) begin
                s_state <= S_HOLD;
              end else begin
                code  <= next_code;
                clear <= 1'b1;
              end
            end
          end
          S_HOLD: begin
            if (!lock_s) begin
              s_state <= S_SEARCH;
              code    <= next_code;
              clear   <= 1'b1;
            end else if (expired && check_en && err_over) begin
              s_state <= S_SEARCH;
              code    <= next_code;
              clear   <= 1'b1;
            end
          end
          default: begin
            s_state <= S_SEARCH;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eq_gain_code <= CODE_MIN;
      eq_code_held <= 1'b0;
    end else begin
      eq_gain_code <= code;
      eq_code_held <= (s_state == S_HOLD);
    end
  end

  eq_dwell_judge #(
    .DWELL_CYCLES (DWELL_CYCLES)
  ) u_judge (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clear     (clear),
    .dwell_sel (search_ctl[DWELL_LSB +: DWELL_W]),
    .err_pulse (err_pulse),
    .err_thr   (err_src[THR_LSB +: THR_W]),
    .expired   (expired),
    .err_over  (err_over)
  );
endmodule

// ---- tb/eq_search_props.sv ----
// Purpose: port checks for the gain search block
// Assumes: dwell parameter handed on by the bind
// Notes:   sees only the top module ports
`timescale 1ns/1ns
module eq_search_props #(
  parameter int DWELL_CYCLES = 40
) (
  input wire logic                             ref_clk,
  input wire logic                             rst,
  input wire logic                             sda_out,
  input wire logic                             sda_oe_n,
  input wire logic                             cdr_lock,
  input wire logic                             digital_soft_reset,
  input wire logic [eq_search_pkg::CODE_W-1:0] eq_gain_code,
  input wire logic                             eq_code_held
);
  import eq_search_pkg::*;
  logic [CODE_W-1:0] last_code;
  logic [3:0]        sr_hist;
  int                gap;
  always_ff @(posedge ref_clk) begin
    last_code <= eq_gain_code;
    sr_hist <= {sr_hist[2:0], digital_soft_reset};
    if (rst || eq_gain_code != last_code) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> eq_gain_code == CODE_MIN && !eq_code_held && sda_oe_n)
    else $error("outputs not idle after reset");
  chk_soft_restart: assert property (
    digital_soft_reset |-> ##[1:3] !eq_code_held)
    else $error("soft reset did not drop hold");
  chk_dwell_gap: assert property (
    eq_gain_code == last_code + 1'b1 && sr_hist == 4'h0
    |-> gap >= DWELL_CYCLES - 1)
    else $error("code stepped before dwell ended");
  chk_no_stall: assert property (
    !eq_code_held && !$past(eq_code_held) && !$past(eq_code_held, 2)
    |-> gap < 8 * DWELL_CYCLES + 8)
    else $error("search stalled without hold");
  chk_code_step: assert property (
    eq_gain_code != last_code && sr_hist == 4'h0
    |-> eq_gain_code == last_code + 1'b1 || eq_gain_code < last_code)
    else $error("code moved other than step or wrap");
  chk_hold_stable: assert property (
    eq_code_held && $past(eq_code_held) |-> $stable(eq_gain_code))
    else $error("code moved while held");
  chk_hold_lock: assert property (
    $rose(eq_code_held) |-> cdr_lock)
    else $error("hold without lock");
  chk_lock_loss: assert property (
    $fell(cdr_lock) && eq_code_held |-> ##[1:8] !eq_code_held)
    else $error("hold kept after lock loss");
  chk_sda_low: assert property (
    !sda_oe_n |-> sda_out == 1'b0)
    else $error("sda driven high");
  cov_held: cover property ($rose(eq_code_held));
  cov_soft: cover property (digital_soft_reset ##2 eq_gain_code != last_code);
  cov_wrap: cover property (eq_gain_code < last_code && sr_hist == 4'h0);
endmodule
bind adaptive_eq_search_control eq_search_props #(
  .DWELL_CYCLES(DWELL_CYCLES)
) u_props (
  .ref_clk(ref_clk),
  .rst(rst),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .cdr_lock(cdr_lock),
  .digital_soft_reset(digital_soft_reset),
  .eq_gain_code(eq_gain_code),
  .eq_code_held(eq_code_held)
);

// ---- tb/serializer_model.sv ----
// Purpose: far-end serializer giving lock and link errors
// Assumes: lock appears only at one good gain code
// Notes:   error pulses every fourth cycle on the chosen source
`timescale 1ns/1ns
module serializer_model (
  input  wire logic                             ref_clk,
  input  wire logic                             link_on,
  input  wire logic [1:0]                       err_sel,
  input  wire logic [eq_search_pkg::CODE_W-1:0] target,
  input  wire logic [eq_search_pkg::CODE_W-1:0] code,
  output logic                                  cdr_lock,
  output logic                                  cdr_error,
  output logic                                  enc_error,
  output logic                                  parity_error,
  output logic                                  compatible_partner
);
  logic [1:0] ph;
  initial begin
    ph = 2'h0;
    cdr_lock = 1'b0;
    cdr_error = 1'b0;
    enc_error = 1'b0;
    parity_error = 1'b0;
  end
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    cdr_lock <= link_on && code == target;
    cdr_error <= err_sel == 2'h1 && ph == 2'h0;
    enc_error <= err_sel == 2'h2 && ph == 2'h0;
    parity_error <= err_sel == 2'h3 && ph == 2'h0;
  end
  assign compatible_partner = link_on;
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the gain search block
// Assumes: dwell shortened to 40 cycles
// Notes:   i2c master is bit-banged here
`timescale 1ns/1ns
module testbench;
  import eq_search_pkg::*;
  localparam int DW = 40;
  localparam int H  = 10;
  logic              ref_clk, rst, scl, sda_m, sda_out, sda_oe_n;
  logic              soft_rst, link_on, cdr_lock, cdr_error, enc_error;
  logic              parity_error, compat, held, obs_v;
  logic [1:0]        err_sel;
  logic [CODE_W-1:0] code, target;
  logic [7:0]        obs, lo, hi;
  logic [7:0]        notes[$];
  int                errors, n_tests;
  wire               sda_w = sda_m & sda_oe_n;
  adaptive_eq_search_control #(.DWELL_CYCLES(DW)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cdr_lock(cdr_lock),
    .cdr_error(cdr_error), .enc_error(enc_error),
    .parity_error(parity_error), .compatible_partner(compat),
    .digital_soft_reset(soft_rst), .eq_gain_code(code),
    .eq_code_held(held));
  serializer_model u_far (
    .ref_clk(ref_clk), .link_on(link_on), .err_sel(err_sel),
    .target(target), .code(code), .cdr_lock(cdr_lock),
    .cdr_error(cdr_error), .enc_error(enc_error),
    .parity_error(parity_error), .compatible_partner(compat));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic note(input logic [7:0] e);
    notes.push_back(e);
  endtask
  task automatic post(input logic [7:0] g);
    obs <= g;
    obs_v <= 1'b1;
    tick(1);
    obs_v <= 1'b0;
    tick(1);
  endtask
  task automatic cmp_byte;
    n_tests++;
    if (notes.size() == 0 || obs !== notes[0]) begin
      errors++;
      $display("BAD %0t got %h", $time, obs);
    end
    if (notes.size() != 0)
      void'(notes.pop_front());
  endtask
  always @(posedge ref_clk) begin
    if (obs_v === 1'b1)
      cmp_byte;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    tick(H);
    scl <= 1'b1;
    tick(H);
    r = sda_w;
    scl <= 1'b0;
    tick(H);
  endtask
  task automatic start_c;
    sda_m <= 1'b1;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda_m <= 1'b0;
    tick(H);
    scl <= 1'b0;
    tick(H);
  endtask
  task automatic stop_c;
    sda_m <= 1'b0;
    tick(H);
    scl <= 1'b1;
    tick(H);
    sda_m <= 1'b1;
    tick(H);
  endtask
  task automatic xfer(input logic [7:0] w, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    start_c;
    xfer(8'h60, q);
    xfer(a, q);
    xfer(v, q);
    stop_c;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] q;
    start_c;
    xfer(8'h60, q);
    xfer(a, q);
    start_c;
    xfer(8'h61, q);
    xfer(8'hff, q);
    stop_c;
    post(q);
  endtask
  task automatic wait_code(input logic [CODE_W-1:0] c);
    int k;
    k = 0;
    while (code !== c && k < 40 * DW) begin
      tick(1);
      k++;
    end
    post({4'h0, code});
  endtask
  task automatic wait_held;
    int k;
    k = 0;
    while (held !== 1'b1 && k < 40 * DW) begin
      tick(1);
      k++;
    end
    post({7'h0, held});
  endtask
  task automatic span(input int n);
    lo = 8'hff;
    hi = 8'h00;
    repeat (n) begin
      tick(1);
      if (code < lo) lo = {4'h0, code};
      if (code > hi) hi = {4'h0, code};
    end
    post(lo);
    post(hi);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    end_of_test;
  end
  initial begin
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    soft_rst = 1'b0;
    link_on = 1'b0;
    err_sel = 2'h0;
    obs = 8'h00;
    obs_v = 1'b0;
    void'($urandom(92329));
    target = 4'($urandom_range(8, 1));
    tick(20);
    rst <= 1'b0;
    tick(5);
    note(ERR_SRC_RST);
    rd(ADDR_ERR_SRC);
    note(CTL_RST);
    rd(ADDR_SEARCH_CTL);
    note(LIMITS_RST);
    rd(ADDR_LIMITS);
    note(8'h00);
    rd(8'h77);
    $display("register defaults done");
    wr(ADDR_LIMITS, 8'h95);
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_SEARCH_CTL, f ? 8'h02 : 8'h06);
      soft_rst <= 1'b1;
      tick(1);
      soft_rst <= 1'b0;
      tick(2);
      note(f ? 8'h00 : 8'h05);
      post({4'h0, code});
      note(f ? 8'h00 : 8'h05);
      note(8'h09);
      span(f ? 12 * DW : 6 * DW);
    end
    $display("range done");
    link_on <= 1'b1;
    note({4'h0, target});
    wait_code(target);
    note(8'h00);
    wait_code(4'h0);
    note(8'h01);
    wait_held;
    note({4'h3, target});
    rd(ADDR_RESULT);
    $display("first lock done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_ERR_SRC, 8'h28 | (8'h01 << i));
      note(8'h01);
      wait_held;
      err_sel <= 2'((i + 1) % 3 + 1);
      tick(3 * DW);
      note({4'h0, target});
      post({4'h0, code});
      err_sel <= 2'(i + 1);
      note({4'h0, target + 4'h1});
      wait_code(target + 4'h1);
      err_sel <= 2'h0;
    end
    $display("error sources done");
    note(8'h01);
    wait_held;
    wr(ADDR_SEARCH_CTL, 8'h1b);
    note(8'h00);
    wait_code(4'h0);
    tick(60);
    note(8'h00);
    post({4'h0, code});
    note(8'h1a);
    rd(ADDR_SEARCH_CTL);
    wr(ADDR_SEARCH_CTL, 8'h02);
    note(8'h01);
    wait_held;
    soft_rst <= 1'b1;
    tick(1);
    soft_rst <= 1'b0;
    note(8'h00);
    wait_code(4'h0);
    note(8'h01);
    wait_held;
    link_on <= 1'b0;
    note({4'h0, target + 4'h1});
    wait_code(target + 4'h1);
    $display("restart and lock loss done");
    tick(4);
    end_of_test;
  end
endmodule
